// *** common/exit_filter_pkg.sv ***
// constants and types for the guest exit filter and fast-call register swap
package exit_filter_pkg;
  localparam int unsigned data_w = 64;
  localparam int unsigned msr_idx_w = 32;
  localparam int unsigned target_count = 4;
  localparam int unsigned area_entries = 8;
  localparam int unsigned area_idx_w = 3;
  localparam int unsigned fast_reg_count = 3;
  // bit positions in the extended feature register
  localparam int unsigned efer_fast_call_bit = 0;
  localparam int unsigned efer_no_exec_bit = 11;
  localparam logic [63:0] efer_feature_mask = 64'h0000_0000_0000_0801;
  // page-fault vector bit in the exception bitmap
  localparam int unsigned page_fault_vector = 14;
  // bitmap ranges of model registers
  localparam logic [31:0] low_range_base = 32'h0000_0000;
  localparam logic [31:0] high_range_base = 32'hc000_0000;
  localparam logic [31:0] range_span = 32'h0000_1fff;
  // model register indexes of the fast-entry set, the update trigger and signature, the extended feature register and the swap pair
  localparam logic [31:0] idx_code_selector = 32'h0000_0174;
  localparam logic [31:0] idx_stack_ptr = 32'h0000_0175;
  localparam logic [31:0] idx_target_ptr = 32'h0000_0176;
  localparam logic [31:0] idx_update_trigger = 32'h0000_0079;
  localparam logic [31:0] idx_update_signature = 32'h0000_008b;
  localparam logic [31:0] idx_extended_feature = 32'hc000_0080;
  localparam logic [31:0] idx_current_seg_base = 32'hc000_0101;
  localparam logic [31:0] idx_kernel_seg_base = 32'hc000_0102;
  // reset values
  localparam logic [63:0] reg_reset = 64'h0000_0000_0000_0000;
  localparam logic [3:0] cnt_reset = 4'h0;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_save = 2'b01,
    st_load = 2'b11,
    st_done = 2'b10
  } phase_e;
endpackage : exit_filter_pkg

// *** hdl/guest_exit_filter_msr_swap.sv ***
// guest exit decision logic and fast-call register movement on exit and entry
`timescale 1ns/1ps
// How it works
// - save control set: guest fast-entry registers go to guest area on exit
// - exit load control set: fast-entry registers reloaded from host area on exit
// - entry load control set: fast-entry registers loaded from guest area on entry
// - feature-enable bits of extended feature register survive exit and entry unless an area load names that register
// - flat fast call/return allowed only in 64-bit mode with fast-call enable
// - segment-base exchange swaps current and kernel base, 64-bit mode only
// - writes to update trigger and signature registers refused during area moves
// - control register reads never exit and return the read shadows
// - control writes changing host-owned mask bits exit, guest-owned ones proceed
// - page-table base load matching any of the first cr3_target_count target entries completes without exit
// - page-fault exits filtered by error-code mask and match
// - configured exit save/load and entry load areas run on every transition
// - bitmap enabled: exit when looked-up read or write bit is set
// - bitmap disabled or address out of range: every access exits
// - each save-area entry gets the value of the register its index names, zero for indexes outside the six decoded registers
module guest_exit_filter_msr_swap
  import exit_filter_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  // guest instruction events
  input wire logic long_mode,
  input wire logic cr_read,
  input wire logic cr_write,
  input wire logic cr_sel,
  input wire logic [63:0] cr_wdata,
  input wire logic cr3_load,
  input wire logic [63:0] cr3_value,
  // model register access
  input wire logic msr_read,
  input wire logic msr_write,
  input wire logic [31:0] msr_index,
  input wire logic [63:0] msr_wdata,
  input wire logic bitmap_read_bit,
  input wire logic bitmap_write_bit,
  // faults and fast-call instructions
  input wire logic page_fault,
  input wire logic [31:0] pf_error_code,
  input wire logic fast_call_instr,
  input wire logic seg_swap_instr,
  // monitor control structure
  input wire logic use_msr_bitmap,
  input wire logic cr3_load_exiting,
  input wire logic [31:0] exception_bitmap,
  input wire logic [31:0] pf_mask,
  input wire logic [31:0] pf_match,
  // control register masks, shadows and guest values
  input wire logic [63:0] cr0_mask,
  input wire logic [63:0] cr4_mask,
  input wire logic [63:0] cr0_shadow,
  input wire logic [63:0] cr4_shadow,
  input wire logic [63:0] cr0_guest,
  input wire logic [63:0] cr4_guest,
  // page-table base target list
  input wire logic [2:0] cr3_target_count,
  input wire logic [63:0] cr3_target0,
  input wire logic [63:0] cr3_target1,
  input wire logic [63:0] cr3_target2,
  input wire logic [63:0] cr3_target3,
  // fast-entry controls and values
  input wire logic save_fast_entry_on_exit,
  input wire logic load_fast_entry_on_exit,
  input wire logic load_fast_entry_on_entry,
  input wire logic [63:0] host_code_selector,
  input wire logic [63:0] host_stack_ptr,
  input wire logic [63:0] host_target_ptr,
  input wire logic [63:0] guest_code_selector,
  input wire logic [63:0] guest_stack_ptr,
  input wire logic [63:0] guest_target_ptr,
  // save and load area walk
  input wire logic [3:0] exit_store_count,
  input wire logic [3:0] exit_load_count,
  input wire logic [3:0] entry_load_count,
  input wire logic [31:0] area_index,
  input wire logic [63:0] area_value,
  // transitions
  input wire logic vm_exit,
  input wire logic vm_entry,
  // results
  output logic [63:0] cr_rdata,
  output logic cause_exit,
  output logic fault_ud,
  // area walk
  output logic [3:0] area_ptr,
  output logic area_load,
  output logic area_store,
  output logic [63:0] area_store_data,
  // saved guest fast-entry values
  output logic [63:0] save_code_selector,
  output logic [63:0] save_stack_ptr,
  output logic [63:0] save_target_ptr,
  output logic save_valid,
  output logic transfer_busy,
  // architectural register state
  output logic [63:0] extended_feature_reg,
  output logic [63:0] current_segment_base,
  output logic [63:0] kernel_segment_base,
  output logic [63:0] fast_entry_code_selector,
  output logic [63:0] fast_entry_stack_ptr,
  output logic [63:0] fast_entry_target_ptr
);

  // true when a model register index falls inside a bitmap range
  function automatic logic in_bitmap_range(input logic [31:0] idx);
    logic [31:0] off_hi;
    off_hi = idx - high_range_base;
    in_bitmap_range = ((idx - low_range_base) <= range_span) || (off_hi <= range_span);
  endfunction

  // true for registers whose writes are refused during area moves
  function automatic logic restricted_msr(input logic [31:0] idx);
    restricted_msr = (idx == idx_update_trigger) || (idx == idx_update_signature);
  endfunction

  phase_e phase;
  phase_e next_phase;
  logic is_exit;
  logic [3:0] limit;
  logic [63:0] msr_value;

  // target list compare, only valid entries count
  logic [63:0] targets [target_count];
  logic [target_count-1:0] target_hit;
  assign targets[0] = cr3_target0;
  assign targets[1] = cr3_target1;
  assign targets[2] = cr3_target2;
  assign targets[3] = cr3_target3;
  genvar g;
  generate
    for (g = 0; g < target_count; g++) begin : g_target
      assign target_hit[g] = (3'(g) < cr3_target_count) && (targets[g] == cr3_value);
    end
  endgenerate

  // exit decisions
  wire logic [63:0] cr_mask_sel = cr_sel ? cr4_mask : cr0_mask;
  wire logic [63:0] cr_cur_sel = cr_sel ? cr4_guest : cr0_guest;
  wire logic cr_host_change = |((cr_wdata ^ cr_cur_sel) & cr_mask_sel);
  wire logic cr_exit = cr_write && cr_host_change;

  // page-table base loads
  wire logic cr3_exit = cr3_load && cr3_load_exiting && !(|target_hit);

  // model register accesses
  wire logic bitmap_ok = use_msr_bitmap && in_bitmap_range(msr_index);
  wire logic bit_sel = msr_read ? bitmap_read_bit : bitmap_write_bit;
  wire logic msr_exit = (msr_read || msr_write) && (!bitmap_ok || bit_sel);

  // page faults
  wire logic pf_matches = ((pf_error_code & pf_mask) == pf_match);
  wire logic pf_exit = page_fault && (exception_bitmap[page_fault_vector] == pf_matches);

  // combined decision and instruction gating
  wire logic any_exit = cr_exit || cr3_exit || msr_exit || pf_exit;
  wire logic fast_call_ok = long_mode && extended_feature_reg[efer_fast_call_bit];
  wire logic ud_now = (fast_call_instr && !fast_call_ok) || (seg_swap_instr && !long_mode);
  wire logic msr_direct_write = msr_write && !msr_exit;

  // transitions are only taken while the area walk is idle
  wire logic exit_take = vm_exit && (phase == st_idle);
  wire logic entry_take = vm_entry && (phase == st_idle);

  // index decode for area loads and direct guest writes
  wire logic area_is_code_sel = (area_index == idx_code_selector);
  wire logic area_is_stack = (area_index == idx_stack_ptr);
  wire logic area_is_target = (area_index == idx_target_ptr);
  wire logic area_is_feature = (area_index == idx_extended_feature);
  wire logic area_is_cur_base = (area_index == idx_current_seg_base);
  wire logic area_is_kern_base = (area_index == idx_kernel_seg_base);
  wire logic wr_is_code_sel = (msr_index == idx_code_selector);
  wire logic wr_is_stack = (msr_index == idx_stack_ptr);
  wire logic wr_is_target = (msr_index == idx_target_ptr);
  wire logic wr_is_feature = (msr_index == idx_extended_feature);
  wire logic wr_is_cur_base = (msr_index == idx_current_seg_base);
  wire logic wr_is_kern_base = (msr_index == idx_kernel_seg_base);

  // read shadow select, registered so the data output comes from a flop
  wire logic [63:0] next_cr_rdata = cr_sel ? cr4_shadow : cr0_shadow;

  // shadow value seen by a guest control read, one cycle after the read
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cr_rdata <= reg_reset;
    end else begin
      cr_rdata <= next_cr_rdata;
    end
  end

  // current value of the register named by the area entry
  always_comb begin
    case (area_index)
      idx_code_selector: msr_value = fast_entry_code_selector;
      idx_stack_ptr: msr_value = fast_entry_stack_ptr;
      idx_target_ptr: msr_value = fast_entry_target_ptr;
      idx_extended_feature: msr_value = extended_feature_reg;
      idx_current_seg_base: msr_value = current_segment_base;
      idx_kernel_seg_base: msr_value = kernel_segment_base;
      default: msr_value = reg_reset;
    endcase
  end

  // last entry of each area phase; an empty area still spends one cycle there
  wire logic store_last = (area_ptr + 4'h1 >= exit_store_count) || (exit_store_count == cnt_reset);
  wire logic load_last = (area_ptr + 4'h1 >= limit) || (limit == cnt_reset);

  // area sequencing: exit stores then loads, entry loads only
  always_comb begin
    next_phase = phase;
    case (phase)
      st_idle: begin
        if (vm_exit) begin
          next_phase = st_save;
        end else if (vm_entry) begin
          next_phase = st_load;
        end
      end
      st_save: begin
        if (store_last) begin
          next_phase = st_load;
        end
      end
      st_load: begin
        if (load_last) begin
          next_phase = st_done;
        end
      end
      // done lasts one cycle, then the walk is idle again
      st_done: next_phase = st_idle;
      default: next_phase = st_idle;
    endcase
  end

  assign limit = is_exit ? exit_load_count : entry_load_count;
  assign area_store = (phase == st_save) && (exit_store_count != cnt_reset);
  assign area_load = (phase == st_load) && (limit != cnt_reset);
  assign transfer_busy = (phase != st_idle);
  wire logic area_write = area_load && !restricted_msr(area_index);

  // phase and area pointer
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      phase <= st_idle;
      area_ptr <= cnt_reset;
      is_exit <= 1'b0;
    end else begin
      phase <= next_phase;
      // the pointer restarts on every phase change
      area_ptr <= (next_phase != phase) ? cnt_reset : area_ptr + 4'h1;
      if (phase == st_idle) begin
        is_exit <= vm_exit;
      end
    end
  end

  // decision outputs and store data
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cause_exit <= 1'b0;
      fault_ud <= 1'b0;
      area_store_data <= reg_reset;
    end else begin
      cause_exit <= any_exit;
      fault_ud <= ud_now;
      area_store_data <= msr_value;
    end
  end

  // guest fast-entry values captured on exit
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      save_code_selector <= reg_reset;
      save_stack_ptr <= reg_reset;
      save_target_ptr <= reg_reset;
      save_valid <= 1'b0;
    end else begin
      save_valid <= exit_take && save_fast_entry_on_exit;
      if (exit_take && save_fast_entry_on_exit) begin
        save_code_selector <= fast_entry_code_selector;
        save_stack_ptr <= fast_entry_stack_ptr;
        save_target_ptr <= fast_entry_target_ptr;
      end
    end
  end

  // fast-entry registers: transitions, then area loads, then guest writes
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fast_entry_code_selector <= reg_reset;
      fast_entry_stack_ptr <= reg_reset;
      fast_entry_target_ptr <= reg_reset;
    end else if (exit_take && load_fast_entry_on_exit) begin
      fast_entry_code_selector <= host_code_selector;
      fast_entry_stack_ptr <= host_stack_ptr;
      fast_entry_target_ptr <= host_target_ptr;
    end else if (entry_take && load_fast_entry_on_entry) begin
      fast_entry_code_selector <= guest_code_selector;
      fast_entry_stack_ptr <= guest_stack_ptr;
      fast_entry_target_ptr <= guest_target_ptr;
    end else if (area_write) begin
      if (area_is_code_sel) fast_entry_code_selector <= area_value;
      if (area_is_stack) fast_entry_stack_ptr <= area_value;
      if (area_is_target) fast_entry_target_ptr <= area_value;
    end else if (msr_direct_write) begin
      if (wr_is_code_sel) fast_entry_code_selector <= msr_wdata;
      if (wr_is_stack) fast_entry_stack_ptr <= msr_wdata;
      if (wr_is_target) fast_entry_target_ptr <= msr_wdata;
    end
  end

  // extended feature register: untouched by transitions themselves
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      extended_feature_reg <= reg_reset;
    end else if (area_write && area_is_feature) begin
      extended_feature_reg <= area_value;
    end else if (msr_direct_write && wr_is_feature) begin
      extended_feature_reg <= msr_wdata;
    end
  end

  // segment bases: exchange in one cycle, otherwise direct or area writes
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      current_segment_base <= reg_reset;
      kernel_segment_base <= reg_reset;
    end else if (seg_swap_instr && long_mode) begin
      current_segment_base <= kernel_segment_base;
      kernel_segment_base <= current_segment_base;
    end else if (area_write) begin
      if (area_is_cur_base) current_segment_base <= area_value;
      if (area_is_kern_base) kernel_segment_base <= area_value;
    end else if (msr_direct_write) begin
      if (wr_is_cur_base) current_segment_base <= msr_wdata;
      if (wr_is_kern_base) kernel_segment_base <= msr_wdata;
    end
  end

endmodule // guest_exit_filter_msr_swap

// *** testbench/exit_filter_checker.sv ***
// concurrent checks on shadow reads, instruction gating and fast-call register movement
`timescale 1ns/1ps
module exit_filter_checker
  import exit_filter_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic cr_read,
  input wire logic cr_sel,
  input wire logic long_mode,
  input wire logic fast_call_instr,
  input wire logic seg_swap_instr,
  input wire logic save_fast_entry_on_exit,
  input wire logic load_fast_entry_on_exit,
  input wire logic load_fast_entry_on_entry,
  input wire logic vm_exit,
  input wire logic vm_entry,
  input wire logic [3:0] exit_store_count,
  input wire logic [63:0] cr0_shadow,
  input wire logic [63:0] cr4_shadow,
  input wire logic [63:0] host_code_selector,
  input wire logic [63:0] guest_code_selector,
  input wire logic [63:0] cr_rdata,
  input wire logic fault_ud,
  input wire logic area_store,
  input wire logic save_valid,
  input wire logic transfer_busy,
  input wire logic [63:0] save_code_selector,
  input wire logic [63:0] extended_feature_reg,
  input wire logic [63:0] current_segment_base,
  input wire logic [63:0] kernel_segment_base,
  input wire logic [63:0] fast_entry_code_selector
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // one assertion per device-side behaviour visible at the ports
  shadow_read_a: assert property (cr_read |=>
    cr_rdata == ($past(cr_sel) ? $past(cr4_shadow) : $past(cr0_shadow)))
    else $error("control read not from shadow");
  call_gate_a: assert property (fast_call_instr && !seg_swap_instr |=>
    fault_ud == !($past(long_mode) && $past(extended_feature_reg[efer_fast_call_bit])))
    else $error("fast call gating wrong");
  swap_gate_a: assert property (seg_swap_instr && !long_mode |=> fault_ud)
    else $error("swap outside long mode allowed");
  base_swap_a: assert property (seg_swap_instr && long_mode && !transfer_busy |=>
    current_segment_base == $past(kernel_segment_base)
    && kernel_segment_base == $past(current_segment_base))
    else $error("segment bases not exchanged");
  save_fast_a: assert property (vm_exit && !transfer_busy && save_fast_entry_on_exit |=>
    save_valid && save_code_selector == $past(fast_entry_code_selector))
    else $error("guest fast-entry value not saved");
  exit_load_a: assert property (vm_exit && !transfer_busy && load_fast_entry_on_exit |=>
    fast_entry_code_selector == $past(host_code_selector))
    else $error("host fast-entry value not loaded");
  entry_load_a: assert property (vm_entry && !transfer_busy && load_fast_entry_on_entry |=>
    fast_entry_code_selector == $past(guest_code_selector))
    else $error("guest fast-entry value not loaded");
  feature_keep_a: assert property ((vm_exit || vm_entry) && !transfer_busy |=>
    $stable(extended_feature_reg))
    else $error("feature bits changed by transition");
  store_run_a: assert property (vm_exit && !transfer_busy && exit_store_count == 4'h2 |=>
    area_store [*2] ##1 !area_store)
    else $error("store area entry count wrong");
  busy_bound_a: assert property ($rose(transfer_busy) |-> ##[1:40] !transfer_busy)
    else $error("transfer never finished");
endmodule // exit_filter_checker
bind guest_exit_filter_msr_swap exit_filter_checker chk_u (.core_clk, .rstn, .cr_read, .cr_sel,
  .long_mode, .fast_call_instr, .seg_swap_instr, .save_fast_entry_on_exit,
  .load_fast_entry_on_exit, .load_fast_entry_on_entry, .vm_exit, .vm_entry, .exit_store_count,
  .cr0_shadow, .cr4_shadow, .host_code_selector, .guest_code_selector, .cr_rdata, .fault_ud,
  .area_store, .save_valid, .transfer_busy, .save_code_selector, .extended_feature_reg,
  .current_segment_base, .kernel_segment_base, .fast_entry_code_selector);

// *** testbench/guest_exit_filter_msr_swap_tb_top.sv ***
// self-checking bench for the guest exit filter and fast-call register swap
`timescale 1ns/1ps
module guest_exit_filter_msr_swap_tb_top
  import exit_filter_pkg::*;
;
  logic core_clk, rstn, long_mode, cr_read, cr_write, cr_sel, cr3_load, msr_read, msr_write;
  logic bitmap_read_bit, bitmap_write_bit, page_fault, fast_call_instr, seg_swap_instr;
  logic use_msr_bitmap, cr3_load_exiting, vm_exit, vm_entry, save_fast_entry_on_exit;
  logic load_fast_entry_on_exit, load_fast_entry_on_entry, cause_exit, fault_ud, area_load;
  logic area_store, save_valid, transfer_busy, ev_q;
  logic [2:0] cr3_target_count;
  logic [3:0] exit_store_count, exit_load_count, entry_load_count, area_ptr;
  logic [31:0] msr_index, pf_error_code, exception_bitmap, pf_mask, pf_match, area_index;
  logic [63:0] cr_wdata, cr3_value, msr_wdata, cr0_mask, cr4_mask, cr0_shadow, cr4_shadow;
  logic [63:0] cr0_guest, cr4_guest, cr3_target0, cr3_target1, cr3_target2, cr3_target3;
  logic [63:0] host_code_selector, host_stack_ptr, host_target_ptr, guest_code_selector;
  logic [63:0] guest_stack_ptr, guest_target_ptr, area_value, cr_rdata, area_store_data;
  logic [63:0] save_code_selector, save_stack_ptr, save_target_ptr, extended_feature_reg;
  logic [63:0] current_segment_base, kernel_segment_base, fast_entry_code_selector;
  logic [63:0] fast_entry_stack_ptr, fast_entry_target_ptr, v, u;
  logic [31:0] seed = 32'haabd4cf3;
  logic [1:0] notes[$];
  int n_errors = 0;
  int checks_done = 0;
  guest_exit_filter_msr_swap dut_u (.*);
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [63:0] r64();
    return {rnd(), rnd()};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // lets the set-up pulse be taken, then drops every event
  task automatic step();
    @(posedge core_clk);
    {cr_read, cr_write, cr3_load, msr_read, msr_write, page_fault, fast_call_instr,
      seg_swap_instr, vm_exit, vm_entry} <= '0;
    @(posedge core_clk);
  endtask
  task automatic fire(input logic [1:0] exp);
    notes.push_back(exp);
    step();
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 80; i++) begin
      @(negedge core_clk);
      if (transfer_busy === 1'b0) break;
    end
    if (i == 80) begin
      n_errors++;
      stop_test();
    end
    @(posedge core_clk);
  endtask
  // one guest instruction pass: fast call and segment swap in and out of long mode
  task automatic instr_round(input logic en);
    for (int k = 0; k < 4; k++) begin
      long_mode <= k[0];
      fast_call_instr <= !k[1];
      seg_swap_instr <= k[1];
      fire({1'b0, !k[0] || (!k[1] && !en)});
    end
  endtask
  task automatic msr_wr(input logic [31:0] idx, input logic [63:0] d);
    {use_msr_bitmap, bitmap_write_bit, msr_index, msr_wdata, msr_write} <= {2'b10, idx, d, 1'b1};
    fire(2'b00);
  endtask
  // monitor: each taken event yields one decision, compared with the oldest note
  always @(posedge core_clk) begin
    ev_q <= |{cr_read, cr_write, cr3_load, msr_read, msr_write, page_fault, fast_call_instr,
      seg_swap_instr};
  end
  always @(negedge core_clk) begin
    if (ev_q) begin
      chk(64'({cause_exit, fault_ud}), 64'(notes.pop_front()));
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    rstn <= 1'b0;
    ev_q <= 1'b0;
    {cr_read, cr_write, cr3_load, msr_read, msr_write, page_fault, fast_call_instr,
      seg_swap_instr, vm_exit, vm_entry, long_mode, cr_sel, bitmap_read_bit} <= '0;
    {bitmap_write_bit, use_msr_bitmap, cr3_load_exiting} <= '0;
    {save_fast_entry_on_exit, load_fast_entry_on_exit, load_fast_entry_on_entry} <= 3'h7;
    {exit_store_count, exit_load_count, entry_load_count, cr3_target_count} <= 15'h108b;
    {msr_index, pf_error_code, exception_bitmap, pf_mask, pf_match, area_index} <= '0;
    {cr_wdata, cr3_value, msr_wdata, cr0_mask, cr4_mask, cr0_shadow, cr4_shadow} <=
      {r64(), r64(), r64(), r64(), r64(), r64(), r64()};
    {cr0_guest, cr4_guest, cr3_target0, cr3_target1, cr3_target2, cr3_target3} <=
      {r64(), r64(), r64(), r64(), r64(), r64()};
    {host_code_selector, host_stack_ptr, host_target_ptr, guest_code_selector} <=
      {r64(), r64(), r64(), r64()};
    {guest_stack_ptr, guest_target_ptr, area_value} <= {r64(), r64(), r64()};
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    // control reads and guest/host-masked control writes
    for (int k = 0; k < 10; k++) begin
      cr_sel <= k[0];
      v = r64() & (k[1] ? ~64'h0 : ~(k[0] ? cr4_mask : cr0_mask));
      cr_wdata <= (k[0] ? cr4_guest : cr0_guest) ^ v;
      {cr_read, cr_write} <= k > 7 ? 2'b10 : 2'b01;
      fire({k < 8 && |(v & (k[0] ? cr4_mask : cr0_mask)), 1'b0});
      if (k > 7) chk(cr_rdata, k[0] ? cr4_shadow : cr0_shadow);
    end
    // page-table base loads against a three-entry target list
    for (int k = 0; k < 6; k++) begin
      cr3_value <= k == 0 ? cr3_target0 : k == 1 ? cr3_target1 : k == 2 ? cr3_target2 :
        k == 3 ? cr3_target3 : r64();
      cr3_load_exiting <= k != 5;
      cr3_load <= 1'b1;
      fire({k == 3 || k == 4, 1'b0});
    end
    // model register accesses over bitmap enable, bitmap bit, range and direction
    for (int k = 0; k < 16; k++) begin
      use_msr_bitmap <= k[0];
      {bitmap_read_bit, bitmap_write_bit} <= {2{k[1]}};
      msr_index <= k[2] ? 32'h3000_0000 : idx_update_signature;
      {msr_read, msr_write} <= {!k[3], k[3]};
      fire({!k[0] || k[1] || k[2], 1'b0});
    end
    // page faults over match and exception-bitmap bit
    for (int k = 0; k < 8; k++) begin
      v = r64();
      {pf_mask, pf_error_code} <= v;
      pf_match <= (v[31:0] & v[63:32]) ^ {31'h0, k[0]};
      exception_bitmap <= {17'h0, k[1], 14'h0};
      page_fault <= 1'b1;
      fire({!k[0] == k[1], 1'b0});
    end
    instr_round(1'b0);
    msr_wr(idx_extended_feature, efer_feature_mask);
    v = r64();
    msr_wr(idx_current_seg_base, v);
    u = r64();
    msr_wr(idx_code_selector, u);
    instr_round(1'b1);
    chk(kernel_segment_base, v);
    chk(current_segment_base, reg_reset);
    // exit with a refused update-trigger area load, then entry loading the segment base
    area_index <= idx_update_trigger;
    vm_exit <= 1'b1;
    step();
    wait_idle();
    chk(save_code_selector, u);
    chk(fast_entry_code_selector, host_code_selector);
    chk(fast_entry_stack_ptr, host_stack_ptr);
    chk(fast_entry_target_ptr, host_target_ptr);
    chk(save_stack_ptr, reg_reset);
    chk(save_target_ptr, reg_reset);
    chk(extended_feature_reg, efer_feature_mask);
    area_index <= idx_current_seg_base;
    vm_entry <= 1'b1;
    step();
    wait_idle();
    chk(fast_entry_code_selector, guest_code_selector);
    chk(current_segment_base, area_value);
    chk(fast_entry_stack_ptr, guest_stack_ptr);
    chk(area_store_data, area_value);
    chk(extended_feature_reg, efer_feature_mask);
    stop_test();
  end
endmodule // guest_exit_filter_msr_swap_tb_top
